// ---- hdl/dcic_top.sv ----
// Display channel serial control: registers, clocking, pending, rx FIFO
//
// Behaviour
// - Match received address to 4-bit short [7:4] or 7-bit full [7:1]
// - Own addresses always readable, writable only while module disabled
// - Clock-control bit 7 set drives acknowledge during reception
// - Bit 6 picks base clock: oscillator/10 when 0, /256 when 1
// - Serial clock equals base clock over prescaler plus one; reset 0xF
// - Bit 5 gates pending onto the interrupt request
// - Own address match sets pending bit 4
// - Arbitration lost as master sets pending
// - Each completed one-byte transfer sets pending
// - Entering transmit-only mode after pre-buffer use sets pending
// - Pending cleared by writing zero or module disable; one ignored
// - Control bit 3 puts pre-buffers between CPU and shift register
// - Pre-buffer bit 0 is normal mode, 1 uses buffers, reset one
// - Module enable bit one enables the whole module
// - Control bit 1 selects transmit-only sync-clock mode or bus mode
//
// Our own choices: the register addresses and strobed register access.
`default_nettype none

module dcic_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      cnt_reg;
   logic [PW:0]      cnt_next;
   logic             ready_reg;
   wire              push = in_valid & ready_reg;
   wire              pop  = out_ready & (cnt_reg != '0);

   assign cnt_next  = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
   assign in_ready  = ready_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign count     = cnt_reg;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Ready is registered so the source sees a clean back-pressure level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
         ready_reg  <= 1'b1;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
         ready_reg  <= 1'b1;
      end else begin
         wr_ptr_reg <= push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= pop  ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
         cnt_reg    <= cnt_next;
         ready_reg  <= (cnt_next != FULL_CNT);
      end
   end
endmodule

// Counter that wraps at a programmable last value, one tick per wrap
module dcic_div #(
   parameter int unsigned W = 9
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic         clear,
   input  wire logic         step,
   input  wire logic [W-1:0] last,
   output logic              tick
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         tick_reg;
   wire logic    wrap = step & (cnt_reg >= last);

   // Compare with >= so a lowered limit never strands the count above it
   assign cnt_next = wrap ? '0 : (step ? W'(cnt_reg + 1'b1) : cnt_reg);
   assign tick     = tick_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (clear) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= wrap;
      end
   end
endmodule

// Own address comparator over the upper bits an address register uses
module dcic_cmp #(
   parameter int unsigned LO = 1
) (
   input  wire logic [7:0] seen,
   input  wire logic [7:0] own,
   output logic            hit
);
   assign hit = (seen[7:LO] == own[7:LO]);
endmodule

module dcic_top (
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // From status/data part
   input  wire logic             module_enable,
   input  wire logic             master_mode,
   input  wire dcic_pkg::dcic_evt_t evt,
   input  wire logic [7:0]       shift_data,
   output logic                  rx_byte_ready,
   // To shift engine
   output logic                  ack_drive,
   output logic                  serial_clock_tick,
   output logic                  addr_match,
   output logic                  ddc1_mode,
   output logic                  prebuf_enable,
   output logic                  irq
);
   localparam int unsigned CW = $clog2(dcic_pkg::FIFO_DEPTH) + 1;

   logic [7:0] short_reg;
   logic [7:0] full_reg;
   logic [7:0] clkic_reg;
   logic [7:0] clkic_next;
   logic       prebuf_reg;
   logic       ddc1_reg;
   logic       ddc1_prev_reg;
   logic       used_reg;
   logic       match_reg;
   logic       ack_reg;
   logic       irq_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       base_tick;
   logic       sck_tick;
   logic       pend_next;

   wire logic [7:0]  fifo_head;
   wire logic        fifo_valid;
   wire logic [CW-1:0] fifo_cnt;

   // Address decode
   wire sel_short = (reg_addr == dcic_pkg::OFS_SHORT);
   wire sel_full  = (reg_addr == dcic_pkg::OFS_FULL);
   wire sel_clkic = (reg_addr == dcic_pkg::OFS_CLKIC);
   wire sel_mode  = (reg_addr == dcic_pkg::OFS_MODE);
   wire sel_rxdat = (reg_addr == dcic_pkg::OFS_RXDAT);
   wire sel_stat  = (reg_addr == dcic_pkg::OFS_STAT);

   wire addr_wr_ok = reg_wr & ~module_enable;
   wire pend_clr   = reg_wr & sel_clkic
                     & ~reg_wdata[dcic_pkg::CC_PEND];
   wire [3:0] pre_val = clkic_reg[dcic_pkg::CC_PRE_HI:0];

   // Own address compare, bus mode only
   wire logic short_hit;
   wire logic full_hit;

   dcic_cmp #(
      .LO (dcic_pkg::SA_LO)
   ) u_short_cmp (
      .seen (evt.addr),
      .own  (short_reg),
      .hit  (short_hit)
   );

   dcic_cmp #(
      .LO (dcic_pkg::FA_LO)
   ) u_full_cmp (
      .seen (evt.addr),
      .own  (full_reg),
      .hit  (full_hit)
   );

   wire addr_seen = evt.addr_valid & module_enable & ~ddc1_reg;
   wire hit       = addr_seen & (short_hit | full_hit);

   // Pending sources
   wire ev_match = hit;
   wire ev_arb   = evt.arb_lost & master_mode;
   wire ev_byte  = evt.byte_done;
   wire ev_ddc1  = ddc1_reg & ~ddc1_prev_reg & used_reg;
   wire pend_set = module_enable
                   & (ev_match | ev_arb | ev_byte | ev_ddc1);

   // Receive bytes land in the buffer only with pre-buffers on
   wire fifo_push = evt.rx_valid & prebuf_reg & module_enable;
   wire fifo_pop  = reg_rd & sel_rxdat & prebuf_reg;
   wire [8:0] base_lim = clkic_reg[dcic_pkg::CC_BASE]
                         ? dcic_pkg::DIV_SLOW
                         : dcic_pkg::DIV_FAST;
   wire [8:0] base_last = 9'(base_lim - 9'h001);

   dcic_fifo #(
      .WIDTH (dcic_pkg::DATA_W),
      .DEPTH (dcic_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .flush     (~module_enable),
      .in_valid  (fifo_push),
      .in_ready  (rx_byte_ready),
      .in_data   (evt.rx_byte),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_head),
      .count     (fifo_cnt)
   );

   // Pending: hardware set beats a same-cycle software clear; disable wins
   always_comb begin
      pend_next = clkic_reg[dcic_pkg::CC_PEND];
      if (pend_clr) begin
         pend_next = 1'b0;
      end
      if (pend_set) begin
         pend_next = 1'b1;
      end
      if (!module_enable) begin
         pend_next = 1'b0;
      end
   end

   always_comb begin
      clkic_next = clkic_reg;
      if (reg_wr && sel_clkic) begin
         clkic_next = reg_wdata;
      end
      clkic_next[dcic_pkg::CC_PEND] = pend_next;
   end

   always_comb begin
      rdata_next = 8'h00;
      case (1'b1)
         sel_short: rdata_next = {short_reg[7:dcic_pkg::SA_LO], 4'h0};
         sel_full:  rdata_next = {full_reg[7:dcic_pkg::FA_LO], 1'b0};
         sel_clkic: rdata_next = clkic_reg;
         sel_mode:  rdata_next = {4'h0, prebuf_reg, match_reg,
                                  ddc1_reg, 1'b0};
         sel_rxdat: rdata_next = prebuf_reg ? fifo_head
                                            : shift_data;
         sel_stat:  rdata_next = {3'h0, fifo_valid,
                                  4'(fifo_cnt)};
         default:   rdata_next = 8'h00;
      endcase
   end

   // Register file
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         short_reg  <= dcic_pkg::SHORT_RST;
         full_reg   <= dcic_pkg::FULL_RST;
         clkic_reg  <= dcic_pkg::CLKIC_RST;
         prebuf_reg <= dcic_pkg::MODE_RST[dcic_pkg::MC_PREBUF];
         ddc1_reg   <= dcic_pkg::MODE_RST[dcic_pkg::MC_DDC1];
      end else begin
         if (addr_wr_ok && sel_short) begin
            short_reg <= reg_wdata;
         end
         if (addr_wr_ok && sel_full) begin
            full_reg <= reg_wdata;
         end
         clkic_reg <= clkic_next;
         if (reg_wr && sel_mode) begin
            prebuf_reg <= reg_wdata[dcic_pkg::MC_PREBUF];
            ddc1_reg   <= reg_wdata[dcic_pkg::MC_DDC1];
         end
      end
   end

   // Pre-buffer use remembered until transmit-only mode is entered or a disable
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ddc1_prev_reg <= 1'b0;
         used_reg      <= 1'b0;
      end else begin
         ddc1_prev_reg <= ddc1_reg;
         if (ev_ddc1 || !module_enable) begin
            used_reg <= 1'b0;
         end else if (prebuf_reg && (ev_byte || fifo_push)) begin
            used_reg <= 1'b1;
         end
      end
   end

   // Match flag lives until the next address or a disable
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         match_reg <= 1'b0;
      end else if (!module_enable) begin
         match_reg <= 1'b0;
      end else if (addr_seen) begin
         match_reg <= hit;
      end
   end

   // Base divider then prescaler; both idle while disabled
   dcic_div #(
      .W (9)
   ) u_base_div (
      .clock (clock),
      .rst_b (rst_b),
      .clear (~module_enable),
      .step  (1'b1),
      .last  (base_last),
      .tick  (base_tick)
   );

   dcic_div #(
      .W (4)
   ) u_pre_div (
      .clock (clock),
      .rst_b (rst_b),
      .clear (~module_enable),
      .step  (base_tick),
      .last  (pre_val),
      .tick  (sck_tick)
   );

   // Outputs
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg   <= 1'b0;
         irq_reg   <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ack_reg <= clkic_reg[dcic_pkg::CC_ACK_EN]
                    & module_enable & ~ddc1_reg;
         irq_reg <= clkic_next[dcic_pkg::CC_PEND]
                    & clkic_next[dcic_pkg::CC_IRQ_EN];
         rdata_reg <= reg_rd ? rdata_next : 8'h00;
      end
   end

   assign reg_rdata         = rdata_reg;
   assign ack_drive         = ack_reg;
   assign serial_clock_tick = sck_tick;
   assign addr_match        = match_reg;
   assign ddc1_mode         = ddc1_reg;
   assign prebuf_enable     = prebuf_reg;
   assign irq               = irq_reg;
endmodule
`default_nettype wire

// ---- hdl/dcic_pkg.sv ----
// Package: register map, field layout, resets, divider counts, carriers
`default_nettype none
package dcic_pkg;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FIFO_DEPTH = 8;

   localparam logic [7:0] OFS_SHORT = 8'h00;
   localparam logic [7:0] OFS_FULL  = 8'h01;
   localparam logic [7:0] OFS_CLKIC = 8'h02;
   localparam logic [7:0] OFS_MODE  = 8'h03;
   localparam logic [7:0] OFS_RXDAT = 8'h04;
   localparam logic [7:0] OFS_STAT  = 8'h05;

   // Clock / interrupt control fields
   localparam int unsigned CC_ACK_EN = 7;
   localparam int unsigned CC_BASE   = 6;
   localparam int unsigned CC_IRQ_EN = 5;
   localparam int unsigned CC_PEND   = 4;
   localparam int unsigned CC_PRE_HI = 3;
   // Mode control fields
   localparam int unsigned MC_PREBUF = 3;
   localparam int unsigned MC_MATCH  = 2;
   localparam int unsigned MC_DDC1   = 1;
   // Own address fields
   localparam int unsigned SA_LO = 4;
   localparam int unsigned FA_LO = 1;
   // Status fields
   localparam int unsigned ST_VALID = 4;
   localparam int unsigned ST_CNT_HI = 3;

   localparam logic [7:0] SHORT_RST = 8'hA0;
   localparam logic [7:0] FULL_RST  = 8'h00;
   localparam logic [7:0] CLKIC_RST = 8'h0F;
   localparam logic [7:0] MODE_RST  = 8'h08;

   localparam logic [8:0] DIV_SLOW = 9'h100;
   localparam logic [8:0] DIV_FAST = 9'h00A;

   // Events from the shift engine
   typedef struct packed {
      logic       addr_valid;
      logic [7:0] addr;
      logic       arb_lost;
      logic       byte_done;
      logic       rx_valid;
      logic [7:0] rx_byte;
   } dcic_evt_t;
endpackage
`default_nettype wire

// ---- verif/dcic_asserts.sv ----
// Checker: bus, event, interrupt and clock timing at the control ports
`default_nettype none
module dcic_asserts (
   input wire logic                clock,
   input wire logic                rst_b,
   input wire logic [7:0]          reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_rdata,
   input wire logic                module_enable,
   input wire logic                master_mode,
   input wire dcic_pkg::dcic_evt_t evt,
   input wire logic                ack_drive,
   input wire logic                serial_clock_tick,
   input wire logic                addr_match,
   input wire logic                ddc1_mode,
   input wire logic                irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  short_reg;
   logic [7:0]  full_reg;
   logic [7:0]  cc_reg;
   logic        seen_reg;
   logic [12:0] gap_reg;
   wire wr_cc = reg_wr && reg_addr == dcic_pkg::OFS_CLKIC;
   wire wr_own = reg_wr && !module_enable;
   wire hit = evt.addr[7:4] == short_reg[7:4]
      || evt.addr[7:1] == full_reg[7:1];
   wire setp = module_enable && (evt.addr_valid && hit && !ddc1_mode
      || evt.arb_lost && master_mode || evt.byte_done);
   wire [12:0] per = (cc_reg[6] ? 13'h0100 : 13'h000A)
      * (13'(cc_reg[3:0]) + 13'h0001);
   // Shadow copies; pending bit is not tracked here
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         short_reg <= dcic_pkg::SHORT_RST;
         full_reg <= dcic_pkg::FULL_RST;
         cc_reg <= dcic_pkg::CLKIC_RST;
         seen_reg <= 1'b0;
         gap_reg <= 13'h0000;
      end else begin
         if (wr_own && reg_addr == dcic_pkg::OFS_SHORT)
            short_reg <= reg_wdata;
         if (wr_own && reg_addr == dcic_pkg::OFS_FULL)
            full_reg <= reg_wdata;
         if (wr_cc)
            cc_reg <= reg_wdata;
         // A rewrite may restart the divider, so that interval is skipped
         seen_reg <= (serial_clock_tick || seen_reg) && !wr_cc
            && module_enable;
         gap_reg <= serial_clock_tick ? 13'h0001 : gap_reg + 13'h0001;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   own_read_a: assert property (
      reg_rd && reg_addr[7:1] == 7'h00 |=> reg_rdata == ($past(reg_addr[0])
      ? {full_reg[7:1], 1'h0} : {short_reg[7:4], 4'h0}))
      else $error("own address readback wrong");
   ack_level_a: assert property (
      ack_drive == $past(cc_reg[7] && module_enable && !ddc1_mode))
      else $error("acknowledge drive wrong");
   irq_gate_a: assert property (
      irq |-> cc_reg[5] && $past(module_enable))
      else $error("interrupt without enable");
   pend_irq_a: assert property (setp |=> irq == cc_reg[5])
      else $error("event did not raise interrupt");
   match_a: assert property (
      evt.addr_valid && module_enable && !ddc1_mode
      |=> addr_match == $past(hit))
      else $error("address match flag wrong");
   tick_gap_a: assert property (
      serial_clock_tick && seen_reg |-> gap_reg == per)
      else $error("serial clock period wrong");
   tick_space_a: assert property (
      serial_clock_tick |=> !serial_clock_tick [*8])
      else $error("serial clock ticks too close");
   cover property (serial_clock_tick && seen_reg);
   cover property ($rose(irq));
   cover property (addr_match && !ddc1_mode);
endmodule
bind dcic_top dcic_asserts u_chk (.clock, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .module_enable, .master_mode, .evt,
   .ack_drive, .serial_clock_tick, .addr_match, .ddc1_mode, .irq);
`default_nettype wire

// ---- verif/dcic_host_model.sv ----
// Partner: host-side event source with receive back-pressure
`default_nettype none
module dcic_host_model (
   input  wire logic           clock,
   input  wire logic           rst_b,
   input  wire logic           go,
   input  wire logic [1:0]     kind,
   input  wire logic [7:0]     data,
   input  wire logic           ready,
   output var dcic_pkg::dcic_evt_t evt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0]          q[$];
   logic [9:0]          h;
   dcic_pkg::dcic_evt_t e;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         evt <= '0;
         q.delete();
      end else begin
         if (go)
            q.push_back({kind, data});
         // A byte offered to a full buffer stays offered until taken
         if (!(evt.rx_valid && !ready)) begin
            e = '0;
            e.addr = ~evt.addr;
            e.rx_byte = ~evt.rx_byte;
            if (q.size() > 0) begin
               h = q.pop_front();
               e.addr_valid = h[9:8] == 2'h0;
               e.arb_lost = h[9:8] == 2'h1;
               e.byte_done = h[9:8] == 2'h2;
               e.rx_valid = h[9:8] == 2'h3;
               if (h[9] == h[8])
                  {e.addr, e.rx_byte} = {h[7:0], h[7:0]};
            end
            evt <= e;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/dcic_tb_top.sv ----
// Bench: register, event, clock and buffer scenarios for the control block
`default_nettype none
module dcic_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        rd_d = 1'b0;
   logic        module_enable = 1'b0;
   logic        master_mode = 1'b0;
   logic [7:0]  shift_data = 8'h00;
   logic        go = 1'b0;
   logic [1:0]  kind = 2'h0;
   logic [7:0]  data = 8'h00;
   logic [7:0]  reg_rdata;
   logic        rx_byte_ready, ack_drive, serial_clock_tick;
   logic        addr_match, ddc1_mode, prebuf_enable, irq;
   dcic_pkg::dcic_evt_t evt;
   logic [7:0]  expq[$];
   logic [7:0]  fifo_b[9];
   logic [7:0]  rst_v[4] = '{8'hA0, 8'h00, 8'h0F, 8'h08};
   logic [31:0] seed = 32'h7536E31D;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          n;
   always #25 clock = ~clock;
   dcic_top DUT (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .module_enable, .master_mode, .evt, .shift_data,
      .rx_byte_ready, .ack_drive, .serial_clock_tick, .addr_match,
      .ddc1_mode, .prebuf_enable, .irq);
   dcic_host_model u_host (.clock, .rst_b, .go, .kind, .data,
      .ready(rx_byte_ready), .evt);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      expq.push_back(exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   task automatic snd(input logic [1:0] k, input logic [7:0] d);
      @(posedge clock);
      go <= 1'b1;
      kind <= k;
      data <= d;
      @(posedge clock);
      go <= 1'b0;
   endtask
   // Skip to one tick, then count cycles to the next
   task automatic tk(input int per);
      @(negedge clock);
      for (n = 0; n < 5000 && !serial_clock_tick; n++)
         @(negedge clock);
      for (n = 1; n < 5000; n++) begin
         @(negedge clock);
         if (serial_clock_tick)
            break;
      end
      check("tick period", 16'(n), 16'(per));
   endtask
   always @(posedge clock) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         conclude();
      end
   end
   // Read data stand only in the cycle after the strobe
   always @(negedge clock)
      if (rd_d)
         check("read data", 16'(reg_rdata), 16'(expq.pop_front()));
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      check("prebuf", 16'(prebuf_enable), 16'h0001);
      foreach (rst_v[i])
         rd(8'(i), rst_v[i]);
      rd(8'h3F, 8'h00);
      wr(8'h00, 8'h5F);
      wr(8'h01, 8'h43);
      rd(8'h00, 8'h50);
      rd(8'h01, 8'h42);
      module_enable <= 1'b1;
      wr(8'h00, 8'hF0);
      rd(8'h00, 8'h50);
      wr(8'h02, 8'hA2);
      tk(30);
      check("ack", 16'(ack_drive), 16'h0001);
      snd(2'h0, 8'h50);
      rd(8'h02, 8'hB2);
      @(negedge clock);
      check("match", 16'(addr_match), 16'h0001);
      check("irq", 16'(irq), 16'h0001);
      wr(8'h02, 8'hA2);
      rd(8'h02, 8'hA2);
      @(negedge clock);
      check("irq", 16'(irq), 16'h0000);
      snd(2'h0, 8'h90);
      rd(8'h02, 8'hA2);
      snd(2'h0, 8'h43);
      rd(8'h02, 8'hB2);
      wr(8'h02, 8'hA2);
      wr(8'h02, 8'hB2);
      snd(2'h1, 8'h00);
      rd(8'h02, 8'hA2);
      master_mode <= 1'b1;
      snd(2'h1, 8'h00);
      rd(8'h02, 8'hB2);
      wr(8'h02, 8'h82);
      snd(2'h2, 8'h00);
      rd(8'h02, 8'h92);
      @(negedge clock);
      check("irq", 16'(irq), 16'h0000);
      @(posedge clock);
      module_enable <= 1'b0;
      rd(8'h02, 8'h82);
      @(negedge clock);
      check("ack", 16'(ack_drive), 16'h0000);
      check("tick", 16'(serial_clock_tick), 16'h0000);
      @(posedge clock);
      module_enable <= 1'b1;
      wr(8'h02, 8'h40);
      tk(256);
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         fifo_b[i] = seed[7:0];
         snd(2'h3, fifo_b[i]);
      end
      @(negedge clock);
      check("ready", 16'(rx_byte_ready), 16'h0000);
      rd(8'h05, 8'h18);
      for (int i = 0; i < 9; i++)
         rd(8'h04, fifo_b[i]);
      rd(8'h05, 8'h00);
      wr(8'h02, 8'h40);
      wr(8'h03, 8'h0A);
      rd(8'h02, 8'h50);
      @(negedge clock);
      check("ddc1", 16'(ddc1_mode), 16'h0001);
      snd(2'h0, 8'h50);
      repeat (2) @(negedge clock);
      check("match", 16'(addr_match), 16'h0000);
      wr(8'h03, 8'h00);
      seed = lfsr(seed);
      shift_data <= seed[7:0];
      rd(8'h04, seed[7:0]);
      @(negedge clock);
      check("prebuf", 16'(prebuf_enable), 16'h0000);
      conclude();
   end
endmodule
`default_nettype wire
